//--- core/mapper_regs.svh
`ifndef MAPPER_REGS_SVH
`define MAPPER_REGS_SVH

// ************************************************************
// sizes
// ************************************************************
`define NUM_PORTS         32
`define NUM_TRIBS         28
`define NUM_STAGES        7
`define NUM_SPARE         4
`define TRIBS_PER_STAGE   4
`define IDX_W             5
`define GRP_W             3
`define ADDR_W            8
`define DATA_W            32
`define BE_W              4
`define STAGE_MSB         4
`define STAGE_LSB         2
`define POS_MSB           1
`define POS_UNUSED        2'h3

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define REG_TX_GROUP      8'h00
`define TX_MAP_PAGE       4'h1
`define REG_RX_GROUP      8'h20
`define RX_MAP_PAGE       4'h3
`define REG_G747          8'h40
`define REG_LOCAL_LOOP    8'h44
`define REG_DS1_LOOP      8'h48
`define REG_DS2_LOOP      8'h4C
`define REG_DS3_CTRL      8'h50
`define REG_RX_STATUS     8'h54
`define MAP_SEL_MSB       3
`define MAP_SEL_LSB       2
`define PAGE_MSB          7
`define PAGE_LSB          4

// ************************************************************
// fields and reset values
// ************************************************************
`define DS3_LINE_LOOP_BIT 0
`define DS3_LOCAL_LOOP_BIT 1
`define READ_UNMAPPED     32'h0000_0000
`define CTRL_RESET        32'h0000_0000
`define GROUP_RESET       3'h0

`endif

//--- core/mapper_pkg.sv
`include "mapper_regs.svh"

package mapper_pkg;

  // ************************************************************
  // types
  // ************************************************************
  typedef logic [`IDX_W-1:0] portIdx_t;
  typedef logic [`GRP_W-1:0] group_t;

  // one serial line: its own clock level and its data bit
  typedef struct packed {
    logic clk;
    logic data;
  } lane_s;

endpackage

//--- core/lane_select.sv
`timescale 1ns/10ps
`include "mapper_regs.svh"

module lane_select (
  // candidate lines
  input  wire mapper_pkg::lane_s    lanes [`NUM_PORTS],
  // selection
  input  wire mapper_pkg::portIdx_t sel,
  input  wire logic                 forceOnes,
  // chosen line
  output mapper_pkg::lane_s         laneOut
);
  import mapper_pkg::*;

  // clock still follows the chosen line so the stream keeps its rate
  always_comb begin
    laneOut      = lanes[sel];
    laneOut.data = forceOnes ? 1'b1 : lanes[sel].data;
  end

endmodule

//--- core/tributary_mapper_and_loops.sv
`timescale 1ns/10ps
`include "mapper_regs.svh"

module tributary_mapper_and_loops (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // register bus, avalon-mm slave
  input  wire logic [`ADDR_W-1:0]   address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [`DATA_W-1:0]   writedata,
  input  wire logic [`BE_W-1:0]     byteenable,
  output logic      [`DATA_W-1:0]   readdata,
  output logic                      waitrequest,
  // low-speed serial ports
  input  wire mapper_pkg::lane_s    portTx       [`NUM_PORTS],
  output mapper_pkg::lane_s         portRx       [`NUM_PORTS],
  // m12 stages
  output mapper_pkg::lane_s         m12TxLane    [`NUM_TRIBS],
  input  wire mapper_pkg::lane_s    m12RxLane    [`NUM_TRIBS],
  // spare links toward the test unit
  input  wire mapper_pkg::lane_s    spareRxLane  [`NUM_SPARE],
  output mapper_pkg::lane_s         spareTxLane  [`NUM_SPARE],
  // ds2 streams around the m23 stage
  input  wire mapper_pkg::lane_s    ds2DemuxLane [`NUM_STAGES],
  input  wire mapper_pkg::lane_s    ds2MuxInLane [`NUM_STAGES],
  output mapper_pkg::lane_s         ds2ToM23Lane [`NUM_STAGES],
  // ds3 line
  input  wire logic                 ds3RxLine,
  input  wire logic                 ds3LineReceiveClock,
  input  wire mapper_pkg::lane_s    ds3TxFromM23,
  output mapper_pkg::lane_s         ds3TxLine,
  output mapper_pkg::lane_s         ds3RxToM23
);
  import mapper_pkg::*;

  // ************************************************************
  // register bus
  // ************************************************************
  logic                   ackR;
  logic [`DATA_W-1:0]     readValue;
  logic                   req;
  logic                   takeWrite;
  logic [1:0]             mapSel;
  logic                   txGroupValid;
  logic                   wrTxMap;
  logic                   wrRxMap;
  group_t                 txGroupR;
  group_t                 rxGroupR;
  portIdx_t               txMapR    [`NUM_TRIBS];
  portIdx_t               rxMapR    [`NUM_PORTS];
  logic [`NUM_STAGES-1:0] g747R;
  logic [`NUM_PORTS-1:0]  localLoopR;
  logic [`NUM_PORTS-1:0]  ds1LoopR;
  logic [`NUM_STAGES-1:0] ds2LoopR;
  logic                   ds3LineLoopR;
  logic                   ds3LocalLoopR;
  logic [`NUM_PORTS-1:0]  rxStatus;

  function automatic logic [`DATA_W-1:0] mergeBytes(input logic [`DATA_W-1:0] old,
                                                    input logic [`DATA_W-1:0] val,
                                                    input logic [`BE_W-1:0]   be);
    logic [`DATA_W-1:0] res;
    res = old;
    for (int b = 0; b < `BE_W; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // one wait cycle: data is latched first, then the edge completes it
  assign req          = read | write;
  assign waitrequest  = req & ~ackR;
  assign takeWrite    = write & ackR;
  assign mapSel       = address[`MAP_SEL_MSB:`MAP_SEL_LSB];
  assign txGroupValid = txGroupR < `GRP_W'(`NUM_STAGES);
  assign wrTxMap = takeWrite && byteenable[0] && txGroupValid &&
                   (address[`PAGE_MSB:`PAGE_LSB] == `TX_MAP_PAGE);
  assign wrRxMap = takeWrite && byteenable[0] &&
                   (address[`PAGE_MSB:`PAGE_LSB] == `RX_MAP_PAGE);

  always_ff @(posedge clock) begin
    if (rst) begin
      ackR <= 1'b0;
    end else begin
      ackR <= req & ~ackR;
    end
  end

  always_comb begin
    readValue = `READ_UNMAPPED;
    if (address == `REG_TX_GROUP) begin
      readValue = `DATA_W'(txGroupR);
    end else if (address[`PAGE_MSB:`PAGE_LSB] == `TX_MAP_PAGE) begin
      readValue = txGroupValid ? `DATA_W'(txMapR[{txGroupR, mapSel}]) : `READ_UNMAPPED;
    end else if (address == `REG_RX_GROUP) begin
      readValue = `DATA_W'(rxGroupR);
    end else if (address[`PAGE_MSB:`PAGE_LSB] == `RX_MAP_PAGE) begin
      readValue = `DATA_W'(rxMapR[{rxGroupR, mapSel}]);
    end else if (address == `REG_G747) begin
      readValue = `DATA_W'(g747R);
    end else if (address == `REG_LOCAL_LOOP) begin
      readValue = localLoopR;
    end else if (address == `REG_DS1_LOOP) begin
      readValue = ds1LoopR;
    end else if (address == `REG_DS2_LOOP) begin
      readValue = `DATA_W'(ds2LoopR);
    end else if (address == `REG_DS3_CTRL) begin
      readValue = `DATA_W'({ds3LocalLoopR, ds3LineLoopR});
    end else if (address == `REG_RX_STATUS) begin
      readValue = rxStatus;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= `READ_UNMAPPED;
    end else if (read && !ackR) begin
      readdata <= readValue;
    end
  end

  // ************************************************************
  // switch group selects
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      txGroupR <= `GROUP_RESET;
      rxGroupR <= `GROUP_RESET;
    end else if (takeWrite && byteenable[0]) begin
      if (address == `REG_TX_GROUP) begin
        txGroupR <= writedata[`GRP_W-1:0];
      end else if (address == `REG_RX_GROUP) begin
        rxGroupR <= writedata[`GRP_W-1:0];
      end
    end
  end

  // ************************************************************
  // maps: separate stores, a write touches only its own direction
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int t = 0; t < `NUM_TRIBS; t++) begin
        txMapR[t] <= `IDX_W'(t);
      end
    end else if (wrTxMap) begin
      txMapR[{txGroupR, mapSel}] <= writedata[`IDX_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        rxMapR[p] <= `IDX_W'(p);
      end
    end else if (wrRxMap) begin
      rxMapR[{rxGroupR, mapSel}] <= writedata[`IDX_W-1:0];
    end
  end

  // ************************************************************
  // format and loop controls
  // ************************************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      g747R         <= `NUM_STAGES'(`CTRL_RESET);
      localLoopR    <= `CTRL_RESET;
      ds1LoopR      <= `CTRL_RESET;
      ds2LoopR      <= `NUM_STAGES'(`CTRL_RESET);
      ds3LineLoopR  <= 1'b0;
      ds3LocalLoopR <= 1'b0;
    end else if (takeWrite) begin
      if (address == `REG_G747 && byteenable[0]) begin
        g747R <= writedata[`NUM_STAGES-1:0];
      end else if (address == `REG_LOCAL_LOOP) begin
        localLoopR <= mergeBytes(localLoopR, writedata, byteenable);
      end else if (address == `REG_DS1_LOOP) begin
        ds1LoopR <= mergeBytes(ds1LoopR, writedata, byteenable);
      end else if (address == `REG_DS2_LOOP && byteenable[0]) begin
        ds2LoopR <= writedata[`NUM_STAGES-1:0];
      end else if (address == `REG_DS3_CTRL && byteenable[0]) begin
        ds3LineLoopR  <= writedata[`DS3_LINE_LOOP_BIT];
        ds3LocalLoopR <= writedata[`DS3_LOCAL_LOOP_BIT];
      end
    end
  end

  // ************************************************************
  // receive switches and port loops
  // ************************************************************
  lane_s rxSrc  [`NUM_PORTS];
  lane_s rxPick [`NUM_PORTS];
  lane_s txEff  [`NUM_PORTS];
  lane_s txPick [`NUM_TRIBS];
  logic  rxForce [`NUM_PORTS];
  logic  txForce [`NUM_TRIBS];

  genvar i;
  generate
    for (i = 0; i < `NUM_TRIBS; i++) begin : g_src
      assign rxSrc[i] = m12RxLane[i];
    end
    for (i = 0; i < `NUM_SPARE; i++) begin : g_spare
      assign rxSrc[`NUM_TRIBS + i] = spareRxLane[i];

      always_ff @(posedge clock) begin
        if (rst) begin
          spareTxLane[i] <= '0;
        end else begin
          spareTxLane[i] <= txEff[`NUM_TRIBS + i];
        end
      end
    end

    for (i = 0; i < `NUM_PORTS; i++) begin : g_port
      // source index above the tributaries is a spare link, never forced
      assign rxForce[i] = (rxMapR[i] < `IDX_W'(`NUM_TRIBS)) &&
                          g747R[rxMapR[i][`STAGE_MSB:`STAGE_LSB]] &&
                          (rxMapR[i][`POS_MSB:0] == `POS_UNUSED);

      lane_select u_rxSel (
        .lanes     (rxSrc),
        .sel       (rxMapR[i]),
        .forceOnes (rxForce[i]),
        .laneOut   (rxPick[i])
      );

      assign txEff[i]    = ds1LoopR[i] ? rxPick[i] : portTx[i];
      assign rxStatus[i] = portRx[i].data;

      // local loop passes the transmit clock along with its data
      always_ff @(posedge clock) begin
        if (rst) begin
          portRx[i] <= '0;
        end else begin
          portRx[i] <= localLoopR[i] ? portTx[i] : rxPick[i];
        end
      end

      a_localLoop: assert property (@(posedge clock) disable iff (rst)
        $past(localLoopR[i]) && !$past(rst) |-> portRx[i] == $past(portTx[i]))
        else $error("local loop lost transmit stream");
      a_ds1LineLoop: assert property (@(posedge clock) disable iff (rst)
        ds1LoopR[i] |-> txEff[i] == rxPick[i])
        else $error("line loop not replacing transmit");
      a_rxIndep: assert property (@(posedge clock) disable iff (rst)
        wrTxMap |=> $stable(rxMapR[i]))
        else $error("transmit map write moved receive map");
      a_rxReset: assert property (@(posedge clock)
        $past(rst) |-> rxMapR[i] == `IDX_W'(i))
        else $error("receive map not straight after reset");
    end

    // ************************************************************
    // transmit switches toward the m12 stages
    // ************************************************************
    for (i = 0; i < `NUM_TRIBS; i++) begin : g_trib
      // a G.747 stage only carries three E1 lines
      assign txForce[i] = g747R[i / `TRIBS_PER_STAGE] &&
                          ((i % `TRIBS_PER_STAGE) == `POS_UNUSED);

      lane_select u_txSel (
        .lanes     (txEff),
        .sel       (txMapR[i]),
        .forceOnes (txForce[i]),
        .laneOut   (txPick[i])
      );

      always_ff @(posedge clock) begin
        if (rst) begin
          m12TxLane[i] <= '0;
        end else begin
          m12TxLane[i] <= txPick[i];
        end
      end

      a_txRoute: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) && !$past(txForce[i]) |->
        m12TxLane[i] == $past(txEff[txMapR[i]]))
        else $error("transmit switch routed wrong port");
      a_txReset: assert property (@(posedge clock)
        $past(rst) |-> txMapR[i] == `IDX_W'(i))
        else $error("transmit map not straight after reset");
    end

    // ************************************************************
    // ds2 loop after the m23 demultiplexer
    // ************************************************************
    for (i = 0; i < `NUM_STAGES; i++) begin : g_stage
      always_ff @(posedge clock) begin
        if (rst) begin
          ds2ToM23Lane[i] <= '0;
        end else begin
          ds2ToM23Lane[i] <= ds2LoopR[i] ? ds2DemuxLane[i] : ds2MuxInLane[i];
        end
      end

      a_ds2Loop: assert property (@(posedge clock) disable iff (rst)
        $past(ds2LoopR[i]) && !$past(rst) |-> ds2ToM23Lane[i] == $past(ds2DemuxLane[i]))
        else $error("ds2 loop not returning demux stream");
      a_g747Ones: assert property (@(posedge clock) disable iff (rst)
        $past(g747R[i]) && !$past(rst) |->
        m12TxLane[i*`TRIBS_PER_STAGE + `TRIBS_PER_STAGE - 1].data)
        else $error("unused G.747 position carries data");
    end
  endgenerate

  // ************************************************************
  // ds3 loops
  // ************************************************************
  lane_s ds3RxLane;
  assign ds3RxLane = '{clk: ds3LineReceiveClock, data: ds3RxLine};

  // line loop: receive clock rides out with the data, no transmit clock needed
  always_ff @(posedge clock) begin
    if (rst) begin
      ds3TxLine <= '0;
    end else begin
      ds3TxLine <= ds3LineLoopR ? ds3RxLane : ds3TxFromM23;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ds3RxToM23 <= '0;
    end else begin
      ds3RxToM23 <= ds3LocalLoopR ? ds3TxFromM23 : ds3RxLane;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_ds3LineLoop;
    @(posedge clock) disable iff (rst)
    $past(ds3LineLoopR) && !$past(rst) |->
    ds3TxLine.data == $past(ds3RxLine) && ds3TxLine.clk == $past(ds3LineReceiveClock);
  endproperty
  a_ds3LineLoop: assert property (p_ds3LineLoop) else $error("ds3 line loop broken");

  property p_busAnswer;
    @(posedge clock) disable iff (rst)
    req && !ackR |-> waitrequest ##1 (!waitrequest && ackR);
  endproperty
  a_busAnswer: assert property (p_busAnswer) else $error("bus answer not in one wait");

  property p_rxOnes;
    @(posedge clock) disable iff (rst)
    rxForce[3] && !localLoopR[3] |=> portRx[3].data;
  endproperty
  a_rxOnes: assert property (p_rxOnes) else $error("unused position not all ones");

  c_localLoop: cover property (@(posedge clock) disable iff (rst) localLoopR[0] ##1 portRx[0].data);
  c_ds3Loop:   cover property (@(posedge clock) disable iff (rst) ds3LineLoopR ##1 ds3TxLine.clk);
  c_txMapWr:   cover property (@(posedge clock) disable iff (rst) wrTxMap);
  c_g747:      cover property (@(posedge clock) disable iff (rst) rxForce[3]);

endmodule

//--- bench/port_line_model.sv
`timescale 1ns/10ps
`include "mapper_regs.svh"

// ************************************************************
// far-side serial lines: each port sends its own clock and data
// ************************************************************
module port_line_model (
  // timing
  input  wire logic              clock,
  input  wire logic              slow,
  // lines into the mapper
  output mapper_pkg::lane_s      portTx [`NUM_PORTS]
);
  import mapper_pkg::*;
  int c;

  // ports four apart send the same sequence, so a wrong pick shows at once unless it is off by a multiple of four
  // slow mode holds each bit four cycles, like a low-rate tributary
  always @(posedge clock) begin
    if (!slow || (c % 4 == 0)) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        portTx[p] <= 2'((c * (2 * p + 101)) >> 1);
      end
    end
    c <= c + 1;
  end
endmodule

//--- bench/tributary_mapper_and_loops_tb.sv
`timescale 1ns/10ps
`include "mapper_regs.svh"

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module tributary_mapper_and_loops_tb;
  import mapper_pkg::*;
  logic clock, rst, read, write, waitrequest, slow, armed;
  logic [7:0] address;
  logic [31:0] writedata, readdata, statM, q;
  logic ds3RxLine, ds3LineReceiveClock;
  lane_s portTx [`NUM_PORTS], portRx [`NUM_PORTS], m12TxLane [`NUM_TRIBS];
  lane_s m12RxLane [`NUM_TRIBS], spareRxLane [`NUM_SPARE], spareTxLane [`NUM_SPARE];
  lane_s ds2DemuxLane [`NUM_STAGES], ds2MuxInLane [`NUM_STAGES], ds2ToM23Lane [`NUM_STAGES];
  lane_s ds3TxFromM23, ds3TxLine, ds3RxToM23;
  logic [4:0] txMapM [`NUM_TRIBS], rxMapM [`NUM_PORTS];
  logic [2:0] txGrp, rxGrp;
  logic [6:0] g747M, ds2M;
  logic [31:0] locM, ds1M;
  logic [1:0] ds3M;
  logic [55:0] eM;
  logic [63:0] eR;
  logic [7:0] eS;
  logic [13:0] eD;
  logic [3:0] e3;
  int failures, checks, cnt;

  tributary_mapper_and_loops DUT (.clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .portTx(portTx), .portRx(portRx), .m12TxLane(m12TxLane),
    .m12RxLane(m12RxLane), .spareRxLane(spareRxLane), .spareTxLane(spareTxLane),
    .ds2DemuxLane(ds2DemuxLane), .ds2MuxInLane(ds2MuxInLane), .ds2ToM23Lane(ds2ToM23Lane),
    .ds3RxLine(ds3RxLine), .ds3LineReceiveClock(ds3LineReceiveClock),
    .ds3TxFromM23(ds3TxFromM23), .ds3TxLine(ds3TxLine), .ds3RxToM23(ds3RxToM23));

  port_line_model partner (.clock(clock), .slow(slow), .portTx(portTx));

  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end

  // ************************************************************
  // line-side sources: sources whose pattern indices are eight apart share one sequence
  // ************************************************************
  function automatic lane_s pat(int k, int c);
    return 2'((c * (2 * k + 3)) >> 2);
  endfunction

  always @(posedge clock) begin
    for (int i = 0; i < 28; i++) m12RxLane[i] <= pat(i, cnt);
    for (int i = 0; i < 4; i++) spareRxLane[i] <= pat(28 + i, cnt);
    for (int i = 0; i < 7; i++) ds2DemuxLane[i] <= pat(32 + i, cnt);
    for (int i = 0; i < 7; i++) ds2MuxInLane[i] <= pat(39 + i, cnt);
    ds3TxFromM23 <= pat(46, cnt);
    {ds3LineReceiveClock, ds3RxLine} <= pat(47, cnt);
    cnt <= cnt + 1;
  end

  // ************************************************************
  // reference of the routing, one cycle ahead of the outputs
  // ************************************************************
  always @(negedge clock) begin : sb
    lane_s rp [`NUM_PORTS];
    lane_s te [`NUM_PORTS];
    lane_s v;
    logic [55:0] gM;
    logic [63:0] gR;
    logic [7:0] gS;
    logic [13:0] gD;
    int s;
    if (rst) armed = 0;
    else begin
      for (int t = 0; t < 28; t++) gM[2*t+:2] = m12TxLane[t];
      for (int p = 0; p < 32; p++) gR[2*p+:2] = portRx[p];
      for (int k = 0; k < 4; k++) gS[2*k+:2] = spareTxLane[k];
      for (int i = 0; i < 7; i++) gD[2*i+:2] = ds2ToM23Lane[i];
      if (armed) begin
        `CHK("m12TxLane", eM, gM)
        `CHK("portRx", eR, gR)
        `CHK("spareTxLane", eS, gS)
        `CHK("ds2ToM23Lane", eD, gD)
        `CHK("ds3 lanes", e3, {ds3TxLine, ds3RxToM23})
      end
      for (int p = 0; p < 32; p++) begin
        s = int'(rxMapM[p]);
        v = (s < 28) ? m12RxLane[s] : spareRxLane[s - 28];
        if (s < 28 && g747M[s / 4] && s % 4 == 3) v.data = 1'b1;
        rp[p] = v;
        te[p] = ds1M[p] ? rp[p] : portTx[p];
        eR[2*p+:2] = locM[p] ? portTx[p] : rp[p];
      end
      for (int t = 0; t < 28; t++) begin
        v = te[txMapM[t]];
        if (g747M[t / 4] && t % 4 == 3) v.data = 1'b1;
        eM[2*t+:2] = v;
      end
      for (int k = 0; k < 4; k++) eS[2*k+:2] = te[28 + k];
      for (int i = 0; i < 7; i++) eD[2*i+:2] = ds2M[i] ? ds2DemuxLane[i] : ds2MuxInLane[i];
      e3[3:2] = ds3M[0] ? {ds3LineReceiveClock, ds3RxLine} : ds3TxFromM23;
      e3[1:0] = ds3M[1] ? ds3TxFromM23 : {ds3LineReceiveClock, ds3RxLine};
      armed = 1;
    end
  end

  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one idle edge before each request so no signal is set twice at an edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    logic [31:0] st;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    // receive bits the status read latches, taken from the reference
    for (int p = 0; p < 32; p++) st[p] = eR[2*p];
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      failures++;
      end_sim();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    statM = st;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    case (a)
      8'h00: txGrp = d[2:0];
      8'h20: rxGrp = d[2:0];
      8'h40: g747M = d[6:0];
      8'h44: locM = d;
      8'h48: ds1M = d;
      8'h4C: ds2M = d[6:0];
      8'h50: ds3M = d[1:0];
      default: begin
        if (a[7:4] == 4'h1 && txGrp < 3'h7) txMapM[txGrp * 4 + a[3:2]] = d[4:0];
        if (a[7:4] == 4'h3) rxMapM[rxGrp * 4 + a[3:2]] = d[4:0];
      end
    endcase
  endtask

  function automatic logic [31:0] expRd(logic [7:0] a);
    case (a)
      8'h00: return {29'h0000_0000, txGrp};
      8'h20: return {29'h0000_0000, rxGrp};
      8'h40: return {25'h0000_0000, g747M};
      8'h44: return locM;
      8'h48: return ds1M;
      8'h4C: return {25'h0000_0000, ds2M};
      8'h50: return {30'h0000_0000, ds3M};
      8'h54: return statM;
      default: begin
        if (a[7:4] == 4'h1 && txGrp < 3'h7) return {27'h0, txMapM[txGrp * 4 + a[3:2]]};
        if (a[7:4] == 4'h3) return {27'h0000_0000, rxMapM[rxGrp * 4 + a[3:2]]};
        return 32'h0000_0000;
      end
    endcase
  endfunction

  task automatic rdChk(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0000_0000);
    `CHK("readdata", expRd(a), q)
  endtask

  task automatic endTest(input string nm);
    $display("test %s done, failures %0d", nm, failures);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst = 1; read = 0; write = 0; address = 8'h00; writedata = 32'h0000_0000;
    slow = 0; armed = 0; cnt = 0; failures = 0; checks = 0; statM = 32'h0000_0000;
    txGrp = 3'h0; rxGrp = 3'h0; g747M = 7'h00; ds2M = 7'h00;
    locM = 32'h0000_0000; ds1M = 32'h0000_0000; ds3M = 2'h0;
    for (int t = 0; t < 28; t++) txMapM[t] = 5'(t);
    for (int p = 0; p < 32; p++) rxMapM[p] = 5'(p);
    ds3TxFromM23 = 2'h0; ds3RxLine = 0; ds3LineReceiveClock = 0;
    for (int i = 0; i < 28; i++) m12RxLane[i] = 2'h0;
    for (int i = 0; i < 7; i++) ds2DemuxLane[i] = 2'h0;
    for (int i = 0; i < 7; i++) ds2MuxInLane[i] = 2'h0;
    for (int i = 0; i < 4; i++) spareRxLane[i] = 2'h0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (20) @(posedge clock);
    for (int k = 0; k < 4; k++) rdChk(8'h10 + 8'(4 * k));
    for (int k = 0; k < 4; k++) rdChk(8'h30 + 8'(4 * k));
    rdChk(8'h60);
    endTest("reset map");
    // last stage, ports from both ends and a spare
    wr(8'h00, 32'h0000_0006);
    wr(8'h10, 32'h0000_001F);
    wr(8'h14, 32'h0000_0000);
    wr(8'h18, 32'h0000_001C);
    wr(8'h1C, 32'h0000_0005);
    for (int k = 0; k < 4; k++) rdChk(8'h10 + 8'(4 * k));
    wr(8'h00, 32'h0000_0007);
    wr(8'h10, 32'h0000_0009);
    rdChk(8'h10);
    rdChk(8'h30);
    repeat (20) @(posedge clock);
    endTest("tx map");
    wr(8'h20, 32'h0000_0007);
    wr(8'h30, 32'h0000_001B);
    wr(8'h34, 32'h0000_0000);
    wr(8'h38, 32'h0000_001F);
    wr(8'h3C, 32'h0000_001C);
    wr(8'h20, 32'h0000_0000);
    wr(8'h30, 32'h0000_001E);
    rdChk(8'h30);
    rdChk(8'h54);
    wr(8'h00, 32'h0000_0006);
    rdChk(8'h1C);
    repeat (20) @(posedge clock);
    endTest("rx map");
    wr(8'h40, 32'hFFFF_FFFF);
    rdChk(8'h40);
    slow <= 1'b1;
    repeat (24) @(posedge clock);
    rdChk(8'h54);
    wr(8'h40, 32'h0000_0041);
    repeat (20) @(posedge clock);
    endTest("g747");
    wr(8'h44, 32'h8000_0001);
    wr(8'h48, 32'h8000_0021);
    wr(8'h4C, 32'h0000_0041);
    rdChk(8'h44);
    rdChk(8'h48);
    rdChk(8'h4C);
    for (int m = 1; m < 4; m++) begin
      wr(8'h50, 32'(m));
      rdChk(8'h50);
      repeat (12) @(posedge clock);
    end
    slow <= 1'b0;
    wr(8'h60, 32'hFFFF_FFFF);
    rdChk(8'h60);
    repeat (20) @(posedge clock);
    endTest("loops");
    end_sim();
  end
endmodule
